// ===== sdlf_defines.svh
`ifndef SDLF_DEFINES_SVH
`define SDLF_DEFINES_SVH

// ****************************************************************
// Storage geometry
// ****************************************************************
`define SDLF_ADDR_W           11
`define SDLF_ENTRY_W          15
`define SDLF_ANC_HALF_BIT     10

// ****************************************************************
// Timing counts
// ****************************************************************
`define SDLF_ANC_INIT_US      82
`define SDLF_ANC_INIT_PCLKS   12'h898

// ****************************************************************
// Host window for extracted words
// ****************************************************************
`define SDLF_HOST_ANC_FIRST   11'h02c
`define SDLF_HOST_ANC_LAST    11'h42b

// ****************************************************************
// Stream codes and reset values
// ****************************************************************
`define SDLF_TRS_ONE          10'h3ff
`define SDLF_TRS_ZERO         10'h000
`define SDLF_XYZ_H_BIT        6
`define SDLF_ANC_HDR_WORDS    11'h007
`define SDLF_PIN_RESET        8'h00
`define SDLF_STRAP_LAST       2'h2
`define SDLF_STRAP_DONE       2'h3

`endif

// ===== sdlf_line_fifo.sv
`timescale 1ns/1ns
`include "sdlf_defines.svh"
module sdlf_line_fifo
  import sdlf_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Write side, recovered pixel domain
  input  wire logic        pixClkPin,
  input  wire logic [9:0]  pixWord,
  input  wire logic        hSync,
  input  wire logic        vSync,
  input  wire logic        fieldBit,
  input  wire logic        errorPacketSeen,
  input  wire logic        auxPacketSeen,
  input  wire logic [10:0] lineNumber,
  input  wire logic        stuffingSyncFlag,
  input  wire logic        codeViolationFlag,
  // Read side and mode pins
  input  wire logic        rdClkPin,
  input  wire logic        rdResetN,
  input  wire logic        fifoEnablePin,
  input  wire logic        processingEnablePin,
  input  wire logic        videoModePin,
  input  wire logic        transportModePin,
  input  wire logic        lockedPin,
  // Host register fields
  input  wire logic        modeWrite,
  input  wire logic [1:0]  modeWriteValue,
  input  wire logic [9:0]  emptyFlagPointerOffset,
  input  wire logic [9:0]  fullFlagPointerOffset,
  input  wire logic [10:0] extractLineFirst,
  input  wire logic [10:0] extractLineSecond,
  input  wire logic        auxExtractGo,
  input  wire logic [39:0] auxTypeFilter,
  input  wire logic [10:0] hostAddr,
  // Outputs
  output logic      [9:0]  outData,
  output logic             outH,
  output logic             outV,
  output logic             outF,
  output logic             outErrPkt,
  output logic             outAuxPkt,
  output logic             outStrobe,
  output logic             fifoEmpty,
  output logic             fifoFull,
  output logic             loadPulseOut,
  output logic      [7:0]  hostReadData,
  output logic      [1:0]  modeField,
  output logic             auxInitDone
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [7:0]  pinMeta;    // First stage, pins
  logic [7:0]  pinSync;    // Second stage, pins
  logic [27:0] inMeta;     // First stage, pixel bus
  logic [27:0] inSync;     // Second stage, pixel bus
  logic        pixPrev;    // Edge history
  logic        rdPrev;
  logic        rstPrev;
  logic        pixTick;    // Pixel clock rose
  logic        rdTick;     // Read clock rose
  logic        rdResetFall;

  // Two flops on every pin and on the pixel bus; host fields and rst_n pass straight in
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pinMeta <= `SDLF_PIN_RESET;
      pinSync <= `SDLF_PIN_RESET;
      inMeta  <= 28'h0000000;
      inSync  <= 28'h0000000;
    end
    else
    begin
      pinMeta <= {lockedPin, transportModePin, videoModePin, processingEnablePin,
                  fifoEnablePin, rdResetN, rdClkPin, pixClkPin};
      pinSync <= pinMeta;
      inMeta  <= {lineNumber, codeViolationFlag, stuffingSyncFlag, auxPacketSeen,
                  errorPacketSeen, fieldBit, vSync, hSync, pixWord};
      inSync  <= inMeta;
    end
  end

  // Edge history of the clocks and read reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pixPrev <= 1'b0;
      rdPrev  <= 1'b0;
      rstPrev <= 1'b0;
    end
    else
    begin
      pixPrev <= pinSync[0];
      rdPrev  <= pinSync[1];
      rstPrev <= pinSync[2];
    end
  end

  assign pixTick     = pinSync[0] & ~pixPrev;
  assign rdTick      = pinSync[1] & ~rdPrev;
  assign rdResetFall = rstPrev & ~pinSync[2];

  // ****************************************************************
  // Mode selection
  // ****************************************************************
  sdlf_mode_e modeReg;   // Programmed mode
  sdlf_mode_e effMode;   // Mode after pin gating
  sdlf_mode_e effPrev;   // Mode last cycle
  logic [1:0] strapCnt;  // Waits for pin sync
  logic       modeChange;

  // Default caught from pins after release, then host owns it
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      modeReg  <= MODE_BYPASS;
      strapCnt <= 2'h0;
    end
    else if (strapCnt != `SDLF_STRAP_DONE)
    begin
      strapCnt <= strapCnt + 2'h1;
      if (strapCnt == `SDLF_STRAP_LAST)
        modeReg <= pinSync[6] ? MODE_STREAM :
                   (pinSync[5] ? MODE_VIDEO : MODE_BYPASS);
    end
    else if (modeWrite)
      modeReg <= sdlf_mode_e'(modeWriteValue);
  end

  // Pin gating of the programmed mode
  always_comb
  begin
    effMode = modeReg;
    if (!pinSync[3] || (modeReg != MODE_STREAM && !pinSync[4]))
      effMode = MODE_BYPASS;
  end

  // Remember mode to spot changes
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      effPrev <= MODE_BYPASS;
    else
      effPrev <= effMode;
  end

  assign modeChange = (effMode != effPrev);

  // ****************************************************************
  // Write-side delay line and pattern detect
  // ****************************************************************
  logic [14:0] dl [0:3];   // dl[3] oldest word
  logic        savSeen;    // SAV sits at dl[3..0]
  logic        adfSeen;    // Packet flag at dl[3..1]
  logic        videoAligned;

  // Shift one word per pixel
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
        dl[i] <= 15'h0000;
    end
    else if (pixTick)
    begin
      dl[0] <= inSync[14:0];
      for (int i = 1; i < 4; i++)
        dl[i] <= dl[i-1];
    end
  end

  assign savSeen = (dl[3][9:0] == `SDLF_TRS_ONE) && (dl[2][9:0] == `SDLF_TRS_ZERO) &&
                   (dl[1][9:0] == `SDLF_TRS_ZERO) && !dl[0][`SDLF_XYZ_H_BIT];
  assign adfSeen = (dl[3][9:0] == `SDLF_TRS_ZERO) && (dl[2][9:0] == `SDLF_TRS_ONE) &&
                   (dl[1][9:0] == `SDLF_TRS_ONE);

  // Video writes begin at the first SAV after entry
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || modeChange)
      videoAligned <= 1'b0;
    else if (pixTick && effMode == MODE_VIDEO && savSeen)
      videoAligned <= 1'b1;
  end

  // ****************************************************************
  // Aux packet extraction
  // ****************************************************************
  logic [11:0] initCnt;    // Pixels since aux entry
  logic        extractOn;  // Extraction armed
  logic        frameStart; // Vertical rise, field one
  logic        lineOk;
  logic        typeOk;
  logic        capStart;
  sdlf_cap_e   capState;
  logic [10:0] capCnt;     // Words written of packet
  logic [10:0] capLen;     // Packet length in words
  logic [10:0] wptr;       // Write pointer, read by capture

  assign auxInitDone = (initCnt == `SDLF_ANC_INIT_PCLKS);

  // Initialisation interval after entering aux mode
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || effMode != MODE_ANC)
      initCnt <= 12'h000;
    else if (pixTick && !auxInitDone)
      initCnt <= initCnt + 12'h001;
  end

  assign frameStart = dl[0][11] & ~dl[1][11] & ~dl[0][12];

  // Arms at a frame start once go is set and init is over
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || effMode != MODE_ANC)
      extractOn <= 1'b0;
    else if (pixTick && frameStart && auxExtractGo && auxInitDone)
      extractOn <= 1'b1;
  end

  // Line and type filters
  always_comb
  begin
    lineOk = ((extractLineFirst == 11'h000) && (extractLineSecond == 11'h000)) ||
             ((extractLineFirst != 11'h000) && (inSync[27:17] == extractLineFirst)) ||
             ((extractLineSecond != 11'h000) && (inSync[27:17] == extractLineSecond));
    typeOk = (auxTypeFilter == 40'h0000000000);
    for (int i = 0; i < 5; i++)
      if (auxTypeFilter[i*8 +: 8] != 8'h00 && auxTypeFilter[i*8 +: 8] == dl[0][7:0])
        typeOk = 1'b1;
  end

  assign capStart = extractOn && capState == CAP_IDLE && adfSeen && typeOk && lineOk;

  // Capture from flag through checksum
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || effMode != MODE_ANC)
    begin
      capState <= CAP_IDLE;
      capCnt   <= 11'h000;
      capLen   <= `SDLF_ANC_HDR_WORDS;
    end
    else if (pixTick)
    begin
      unique case (capState)
        CAP_IDLE:
        begin
          if (capStart)
          begin
            capState <= CAP_RUN;
            capCnt   <= 11'h001;
            capLen   <= `SDLF_ANC_HDR_WORDS;
          end
        end
        CAP_RUN:
        begin
          capCnt <= capCnt + 11'h001;
          if (capCnt == 11'h002)
            capLen <= `SDLF_ANC_HDR_WORDS + {3'h0, dl[0][7:0]};
          if (capCnt == capLen - 11'h001 || wptr[`SDLF_ANC_HALF_BIT])
            capState <= CAP_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Memory, pointers and flags
  // ****************************************************************
  logic [14:0] mem [0:2047];  // Line storage
  logic [10:0] rptr;
  logic        wrEn;
  logic [10:0] wrAddr;
  logic [14:0] wrData;
  logic        pop;
  logic [10:0] usedCnt;
  logic [10:0] freeCnt;
  logic        emptyFlag;
  logic        fullFlag;
  logic        vidReset;      // Read reset honoured
  logic [10:0] hostIdx;

  // Write request per mode
  always_comb
  begin
    wrEn   = 1'b0;
    wrAddr = wptr;
    wrData = dl[2];
    unique case (effMode)
      MODE_VIDEO:
      begin
        wrEn = pixTick && (savSeen || (videoAligned && !fullFlag));
        if (savSeen)
          wrAddr = 11'h000;
      end
      MODE_STREAM:
      begin
        wrEn   = pixTick && !inSync[15] && !fullFlag;
        wrData = {5'h00, inSync[16], inSync[15], inSync[7:0]};
      end
      MODE_ANC:
      begin
        wrEn   = pixTick && (capStart || capState == CAP_RUN) &&
                 !wptr[`SDLF_ANC_HALF_BIT];
        wrData = {7'h00, dl[3][7:0]};
      end
      MODE_BYPASS:
        wrEn = 1'b0;
    endcase
  end

  // Write port, idle in bypass
  always_ff @(posedge core_clk)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
  end

  assign usedCnt  = wptr - rptr;
  assign freeCnt  = rptr - wptr;
  assign vidReset = (effMode == MODE_VIDEO) && rdResetFall;
  assign hostIdx  = hostAddr - `SDLF_HOST_ANC_FIRST;

  // Pointers and flags, set beats clear
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || modeChange)
    begin
      wptr      <= 11'h000;
      rptr      <= 11'h000;
      emptyFlag <= 1'b1;
      fullFlag  <= 1'b0;
    end
    else
    begin
      if (wrEn)
        wptr <= wrAddr + 11'h001;
      if (vidReset)
        rptr <= 11'h000;
      else if (pop)
        rptr <= rptr + 11'h001;
      if (pop && !wrEn && (rptr + 11'h001 == wptr))
        emptyFlag <= 1'b1;
      else if (usedCnt > {1'b0, emptyFlagPointerOffset})
        emptyFlag <= 1'b0;
      if (wrEn && !pop && (wrAddr + 11'h001 == rptr))
        fullFlag <= 1'b1;
      else if (freeCnt > {1'b0, fullFlagPointerOffset})
        fullFlag <= 1'b0;
    end
  end

  // ****************************************************************
  // Two-entry output buffer
  // ****************************************************************
  logic [14:0] buf0;
  logic [14:0] buf1;
  logic [1:0]  bufCount;
  logic        drain;
  logic [14:0] outReg;

  assign pop   = !emptyFlag && bufCount != 2'h2 && !vidReset &&
                 (effMode == MODE_VIDEO || effMode == MODE_STREAM);
  assign drain = rdTick && bufCount != 2'h0 && effMode != MODE_BYPASS;

  // Prefetch from memory, drain on read edges
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || modeChange || vidReset)
    begin
      bufCount <= 2'h0;
      buf0     <= 15'h0000;
      buf1     <= 15'h0000;
    end
    else
    begin
      unique case ({pop, drain})
        2'b10:
        begin
          if (bufCount == 2'h0)
            buf0 <= mem[rptr];
          else
            buf1 <= mem[rptr];
          bufCount <= bufCount + 2'h1;
        end
        2'b01:
        begin
          buf0     <= buf1;
          bufCount <= bufCount - 2'h1;
        end
        2'b11:
        begin
          if (bufCount == 2'h1)
            buf0 <= mem[rptr];
          else
          begin
            buf0 <= buf1;
            buf1 <= mem[rptr];
          end
        end
        2'b00:
          bufCount <= bufCount;
      endcase
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      outReg       <= 15'h0000;
      outStrobe    <= 1'b0;
      loadPulseOut <= 1'b0;
      hostReadData <= 8'h00;
    end
    else
    begin
      outStrobe    <= 1'b0;
      loadPulseOut <= wrEn && effMode == MODE_VIDEO && savSeen;
      if (effMode == MODE_BYPASS && pixTick)
      begin
        outReg    <= inSync[14:0];
        outStrobe <= 1'b1;
      end
      else if (drain)
      begin
        outReg    <= buf0;
        outStrobe <= 1'b1;
      end
      if (pinSync[7] && effMode == MODE_ANC && hostAddr >= `SDLF_HOST_ANC_FIRST &&
          hostAddr <= `SDLF_HOST_ANC_LAST)
        hostReadData <= mem[hostIdx][7:0];
      else
        hostReadData <= 8'h00;
    end
  end

  assign outData   = outReg[9:0];
  assign outH      = outReg[10];
  assign outV      = outReg[11];
  assign outF      = outReg[12];
  assign outErrPkt = outReg[13];
  assign outAuxPkt = outReg[14];
  assign fifoEmpty = emptyFlag;
  assign fifoFull  = fullFlag;
  assign modeField = modeReg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_BYPASS_STATIC: assert property (@(posedge core_clk) disable iff (!rst_n)
    effMode == MODE_BYPASS |-> !wrEn) else $error("memory written in bypass");
  AST_PIN_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pinSync[3] |-> effMode == MODE_BYPASS) else $error("fifo enable pin ignored");
  AST_NO_STUFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    (effMode == MODE_STREAM && inSync[15]) |-> !wrEn) else $error("stuffing written");
  AST_INIT_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (effMode == MODE_ANC && !auxInitDone) |-> !wrEn) else $error("extract before init");
  AST_MODE_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    modeChange |=> (wptr == 11'h000 && rptr == 11'h000 && emptyFlag && !fullFlag))
    else $error("pointers not cleared on mode change");
  AST_EMPTY_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pop && !wrEn && !modeChange && rptr + 11'h001 == wptr) |=> emptyFlag)
    else $error("empty flag missed");
  AST_FULL_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wrEn && !pop && !modeChange && wrAddr + 11'h001 == rptr) |=> fullFlag)
    else $error("full flag missed");
  AST_READ_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (vidReset && !modeChange) |=> (rptr == 11'h000 && bufCount == 2'h0))
    else $error("read reset did not realign");
  AST_ANC_HALF: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wrEn && effMode == MODE_ANC) |-> !wrAddr[`SDLF_ANC_HALF_BIT])
    else $error("aux write outside first half");
  AST_DRAIN_OUT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (drain && !modeChange) |=> (outStrobe && outReg == $past(buf0)))
    else $error("read edge did not present word");

endmodule : sdlf_line_fifo

// ===== sdlf_line_fifo_tb.sv
`timescale 1ns/1ns
module sdlf_line_fifo_tb
  import sdlf_pkg::*;
;
  // ****************************************************************
  // Stimulus rows: byte, stuffing, word error, expected entry
  // ****************************************************************
  typedef struct { logic [7:0] b; logic s; logic c; logic [9:0] e; } sdlf_row_s;
  sdlf_row_s rows [6] = '{'{8'h47, 1'b0, 1'b0, 10'h047}, '{8'hbc, 1'b1, 1'b0, 10'h0bc},
                          '{8'hff, 1'b0, 1'b1, 10'h2ff}, '{8'h00, 1'b0, 1'b0, 10'h000},
                          '{8'hbc, 1'b1, 1'b1, 10'h2bc}, '{8'ha5, 1'b0, 1'b1, 10'h2a5}};
  logic        core_clk, rst_n, pixClkPin, hSync, vSync, fieldBit, errorPacketSeen;
  logic        auxPacketSeen, stuffingSyncFlag, codeViolationFlag, fifoEnablePin;
  logic        processingEnablePin, videoModePin, transportModePin, lockedPin;
  logic        modeWrite, auxExtractGo, outH, outV, outF, outErrPkt, outAuxPkt;
  logic        outStrobe, fifoEmpty, fifoFull, loadPulseOut, auxInitDone;
  logic [9:0]  pixWord, emptyFlagPointerOffset, fullFlagPointerOffset, outData;
  logic [10:0] lineNumber, extractLineFirst, extractLineSecond, hostAddr;
  logic [1:0]  modeWriteValue, modeField;
  logic [39:0] auxTypeFilter;
  logic [7:0]  hostReadData;
  wire         rdClkPin, rdResetN;
  logic [9:0]  got [$];                // Words seen at strobes
  logic [9:0]  exp [$];                // Words expected
  int          num_errors, n_checks, cycles;
  int          nLoads;                 // Load pulses seen
  logic [9:0]  vid [8] = '{10'h3ff, 10'h000, 10'h000, 10'h080, 10'h015, 10'h200,
                           10'h200, 10'h200}; // SAV, one word, flush

  sdlf_reader sdlf_reader_i (.rdClkPin, .rdResetN);
  sdlf_line_fifo sdlf_line_fifo_i (.core_clk, .rst_n, .pixClkPin, .pixWord, .hSync, .vSync,
    .fieldBit, .errorPacketSeen, .auxPacketSeen, .lineNumber, .stuffingSyncFlag,
    .codeViolationFlag, .rdClkPin, .rdResetN, .fifoEnablePin, .processingEnablePin,
    .videoModePin, .transportModePin, .lockedPin, .modeWrite, .modeWriteValue,
    .emptyFlagPointerOffset, .fullFlagPointerOffset, .extractLineFirst, .extractLineSecond,
    .auxExtractGo, .auxTypeFilter, .hostAddr, .outData, .outH, .outV, .outF, .outErrPkt,
    .outAuxPkt, .outStrobe, .fifoEmpty, .fifoFull, .loadPulseOut, .hostReadData, .modeField,
    .auxInitDone);

  // ****************************************************************
  // Clock, strobe capture and hang guard
  // ****************************************************************
  always #5 core_clk = ~core_clk;

  // Collect output words; stop a hung run
  always @(posedge core_clk)
  begin
    if (outStrobe === 1'b1)
      got.push_back(outData);
    if (loadPulseOut === 1'b1)
      nLoads++;
    cycles++;
    if (cycles == 80000)
    begin
      num_errors++;
      close_out();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Compare one flag
  task automatic chkb(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chkb

  // Compare one word or count
  task automatic chkw(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chkw

  // One pixel tick; data set a cycle before the pin rises
  task automatic px(input logic [9:0] b, input logic s, input logic c);
    @(posedge core_clk);
    pixWord <= b;
    stuffingSyncFlag <= s;
    codeViolationFlag <= c;
    {hSync, vSync, fieldBit, errorPacketSeen, auxPacketSeen} <= b[4:0];
    lineNumber <= lineNumber + 11'h001;
    @(posedge core_clk);
    pixClkPin <= 1'b1;
    repeat (3) @(posedge core_clk);
    pixClkPin <= 1'b0;
    @(posedge core_clk);
  endtask : px

  // Stored word with flags low
  task automatic pw(input logic [7:0] b);
    px({2'b00, b}, 1'b0, 1'b0);
    exp.push_back({2'b00, b});
  endtask : pw

  // Host write of the mode field
  task automatic setmode(input logic [1:0] m);
    @(posedge core_clk);
    modeWrite <= 1'b1;
    modeWriteValue <= m;
    @(posedge core_clk);
    modeWrite <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : setmode

  // Read all expected words plus extra edges, compare in order
  task automatic drain(input int extra);
    sdlf_reader_i.burst(exp.size() + extra);
    repeat (8) @(posedge core_clk);
    chkw("count", 12'(exp.size()), 12'(got.size()));
    while (exp.size() > 0 && got.size() > 0)
      chkw("word", {2'b00, exp.pop_front()}, {2'b00, got.pop_front()});
    exp.delete();
    got.delete();
  endtask : drain

  // Print counts and verdict
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {core_clk, pixClkPin, hSync, vSync, fieldBit, errorPacketSeen, auxPacketSeen} = '0;
    {stuffingSyncFlag, codeViolationFlag, modeWrite, auxExtractGo, lockedPin} = '0;
    {rst_n, pixWord, lineNumber, modeWriteValue, hostAddr, auxTypeFilter} = '0;
    {emptyFlagPointerOffset, fullFlagPointerOffset} = '0;
    {extractLineFirst, extractLineSecond} = '0;
    {fifoEnablePin, processingEnablePin, videoModePin, transportModePin} = 4'hf;
    repeat (3) @(posedge core_clk);
    #1;
    chkb("empty", 1'b1, fifoEmpty);
    chkb("full", 1'b0, fifoFull);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chkw("mode", 12'(MODE_STREAM), {10'h000, modeField});
    // Stream rows; processing pin low does not matter
    processingEnablePin <= 1'b0;
    foreach (rows[i])
    begin
      px({2'b00, rows[i].b}, rows[i].s, rows[i].c);
      if (!rows[i].s)
        exp.push_back(rows[i].e);
    end
    repeat (6) @(posedge core_clk);
    chkb("empty", 1'b0, fifoEmpty);
    sdlf_reader_i.pulse_reset();
    drain(2);
    chkb("empty", 1'b1, fifoEmpty);
    // Empty offset holds the flag until passed
    emptyFlagPointerOffset <= 10'h003;
    repeat (3) pw(8'h31);
    repeat (6) @(posedge core_clk);
    chkb("empty", 1'b1, fifoEmpty);
    pw(8'h32);
    repeat (6) @(posedge core_clk);
    chkb("empty", 1'b0, fifoEmpty);
    drain(0);
    // Fill 2048 entries plus two held in the output buffer
    for (int k = 0; k < 2050; k++)
      pw(k[7:0]);
    repeat (6) @(posedge core_clk);
    chkb("full", 1'b1, fifoFull);
    px(10'h0ee, 1'b0, 1'b0);
    drain(0);
    chkb("full", 1'b0, fifoFull);
    // Host window reads zero outside aux mode
    lockedPin <= 1'b1;
    hostAddr <= 11'h02c;
    repeat (4) @(posedge core_clk);
    chkw("host", 12'h000, {4'h0, hostReadData});
    // Bypass field clears pointers and passes words through
    pw(8'h11);
    setmode(MODE_BYPASS);
    chkw("mode", 12'(MODE_BYPASS), {10'h000, modeField});
    chkb("empty", 1'b1, fifoEmpty);
    exp.delete();
    got.delete();
    pw(8'h5a);
    setmode(MODE_STREAM);
    fifoEnablePin <= 1'b0;
    pw(8'h3c);
    repeat (8) @(posedge core_clk);
    chkw("count", 12'(exp.size()), 12'(got.size()));
    while (exp.size() > 0 && got.size() > 0)
      chkw("bypass", {2'b00, exp.pop_front()}, {2'b00, got.pop_front()});
    // Video: SAV lands at address zero, read reset rewinds
    fifoEnablePin <= 1'b1;
    processingEnablePin <= 1'b1;
    setmode(MODE_VIDEO);
    chkw("mode", 12'(MODE_VIDEO), {10'h000, modeField});
    foreach (vid[i])
      px(vid[i], 1'b0, 1'b0);
    repeat (6) @(posedge core_clk);
    chkw("loads", 12'h001, 12'(nLoads));
    sdlf_reader_i.burst(2);
    got.delete();
    sdlf_reader_i.pulse_reset();
    exp = '{10'h000, 10'h000, 10'h080, 10'h015};
    drain(1);
    chkb("h", 1'b1, outH);
    chkb("v", 1'b0, outV);
    chkb("f", 1'b1, outF);
    chkb("err", 1'b0, outErrPkt);
    chkb("aux", 1'b1, outAuxPkt);
    // Aux mode: init interval ends at exactly 2200 pixels
    setmode(MODE_ANC);
    repeat (2199) px(10'h000, 1'b0, 1'b0);
    chkb("init", 1'b0, auxInitDone);
    px(10'h000, 1'b0, 1'b0);
    chkb("init", 1'b1, auxInitDone);
    close_out();
  end
endmodule : sdlf_line_fifo_tb

// ===== sdlf_pkg.sv
package sdlf_pkg;

  // ****************************************************************
  // Operating modes as programmed in the mode field
  // ****************************************************************
  typedef enum logic [1:0]
  {
    MODE_VIDEO  = 2'h0,
    MODE_STREAM = 2'h1,
    MODE_ANC    = 2'h2,
    MODE_BYPASS = 2'h3
  } sdlf_mode_e;

  // ****************************************************************
  // Packet capture states
  // ****************************************************************
  typedef enum logic
  {
    CAP_IDLE = 1'b0,
    CAP_RUN  = 1'b1
  } sdlf_cap_e;

endpackage : sdlf_pkg

// ===== sdlf_reader.sv
`timescale 1ns/1ns
module sdlf_reader
(
  // Read side pins toward the block
  output logic rdClkPin,
  output logic rdResetN
);
  // ****************************************************************
  // Downstream reader with its own 125 ns read clock
  // ****************************************************************
  // Read clock stands low outside bursts
  initial
  begin
    rdClkPin = 1'b0;
    rdResetN = 1'b1;
  end

  // Clean burst of whole read periods, no runt pulses
  task automatic burst(input int n);
    #2;
    repeat (n)
    begin
      #62 rdClkPin = 1'b1;
      #63 rdClkPin = 1'b0;
    end
  endtask : burst

  // Read reset low for less than one read period
  task automatic pulse_reset();
    #2;
    #62 rdResetN = 1'b0;
    #63 rdResetN = 1'b1;
  endtask : pulse_reset
endmodule : sdlf_reader
